// ### core/machine_cycle_timer.sv
// machine-cycle counter: marks the last oscillator clock of each machine cycle
`timescale 1ns/1ps
module machine_cycle_timer #(
  parameter int width = pm_clock_pkg::phase_count_width
) (
  input wire logic clk,
  input wire logic rst,
  input wire pm_clock_pkg::divider_select_t divider,
  output logic cycle_end,
  output logic [1:0] phase
);
  import pm_clock_pkg::*;

  logic [width-1:0] count;
  logic [width-1:0] last;

  // ---------------------------------------------------------------
  // terminal count per divider
  // ---------------------------------------------------------------
  always_comb begin
    case (divider)
      reduced_speed_div64: last = width'(clocks_div64 - 1);
      reduced_speed_div1024: last = width'(clocks_div1024 - 1);
      default: last = width'(clocks_full_speed - 1);
    endcase
  end

  assign cycle_end = (count == last);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || cycle_end) begin
      count <= '0;
    end else begin
      count <= count + width'(1);
    end
  end

  // internal clock phase C1..C4 as quarter of the cycle
  always_comb begin
    case (divider)
      reduced_speed_div64: phase = count[5:4];
      reduced_speed_div1024: phase = count[9:8];
      default: phase = count[1:0];
    endcase
  end
endmodule

// ### core/pm_clock_pkg.sv
// package: register map, field layout and encodings for the power-management clock divider
package pm_clock_pkg;

  // ---------------------------------------------------------------
  // register map (word indices and byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] power_mgmt_control_addr = 12'h0C4;
  localparam logic [11:0] activity_status_addr = 12'h0C5;
  localparam logic [11:0] activity_status_index = 12'h0C5;
  localparam logic [11:0] activity_status_byte_addr = 12'h314;
  localparam logic [11:0] power_mgmt_control_byte_addr = 12'h310;
  localparam logic [11:0] osc_select_byte_addr = 12'h318;

  // ---------------------------------------------------------------
  // power_mgmt_control fields
  // ---------------------------------------------------------------
  localparam int divider_select_hi_pos = 7;
  localparam int divider_select_lo_pos = 6;
  localparam int switchback_enable_pos = 5;
  localparam logic switchback_enable_reset = 1'b0;

  // ---------------------------------------------------------------
  // activity_status fields
  // ---------------------------------------------------------------
  localparam int power_fail_in_progress_pos = 7;
  localparam int high_prio_in_progress_pos = 6;
  localparam int low_prio_in_progress_pos = 5;
  localparam int serial1_tx_active_pos = 3;
  localparam int serial1_rx_active_pos = 2;
  localparam int serial0_tx_active_pos = 1;
  localparam int serial0_rx_active_pos = 0;
  localparam logic [7:0] activity_status_reset = 8'h00;

  // ---------------------------------------------------------------
  // oscillator select register field
  // ---------------------------------------------------------------
  localparam int ring_run_pos = 0;
  localparam logic ring_run_reset = 1'b0;

  // ---------------------------------------------------------------
  // divider encodings and clocks per machine cycle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    div_reserved = 2'b00,
    div_full_speed = 2'b01,
    reduced_speed_div64 = 2'b10,
    reduced_speed_div1024 = 2'b11
  } divider_select_t;

  localparam divider_select_t divider_select_reset = div_full_speed;
  localparam int clocks_full_speed = 4;
  localparam int clocks_div64 = 64;
  localparam int clocks_div1024 = 1024;
  localparam int phase_count_width = 10;

endpackage

// ### core/power_mgmt_clock_divider.sv
// power-management clock divider with switchback and activity status, APB slave
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps

// Functional notes
// - reset runs four clocks per machine cycle
// - reduced modes use 64 or 1024 clocks
// - divider codes: 00 reserved,01/10/11 = 4/64/1024
// - 01 anytime; 10/11 only from 01
// - illegal divider transitions ignored, bits unchanged
// - switchback enable resets 0, inert when 0
// - switchback forces divider back to 01
// - acknowledged external interrupt triggers switchback
// - enabled serial receiver falling edge triggers switchback
// - transmit buffer load triggers switchback
// - read-only activity status, resets to zero
// - bit 7 power-fail service in progress
// - bit 6 high-priority service in progress
// - bit 5 low-priority service in progress
// - bit 3 second port transmitter active
// - bit 2 second port receiver active
// - bit 1 first port transmitter active
// - ring oscillator may run in normal operation
module power_mgmt_clock_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_ack,
  input wire logic power_fail_in_service,
  input wire logic high_prio_in_progress,
  input wire logic low_prio_in_progress,
  input wire logic serial0_rx_enable,
  input wire logic serial1_rx_enable,
  input wire logic serial0_rx_pin,
  input wire logic serial1_rx_pin,
  input wire logic serial0_tx_load,
  input wire logic serial1_tx_load,
  input wire logic serial0_tx_busy,
  input wire logic serial1_tx_busy,
  input wire logic serial0_rx_busy,
  input wire logic serial1_rx_busy,
  output pm_clock_pkg::divider_select_t divider_select,
  output logic [1:0] machine_phase,
  output logic machine_cycle_end,
  output logic ring_osc_run
);
  import pm_clock_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  divider_select_t requested;
  logic switchback_enable;
  logic [7:0] activity_status;
  logic rx0_prev;
  logic rx1_prev;
  logic cycle_end;
  logic [1:0] phase;

  logic access;
  logic wr;
  logic hit_ctrl;
  logic hit_status;
  logic hit_osc;
  logic mapped;
  logic ctrl_write;
  logic [1:0] wr_div;
  logic div_write_ok;
  logic rx0_fall;
  logic rx1_fall;
  logic switchback_event;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign hit_ctrl = (paddr == power_mgmt_control_byte_addr);
  assign hit_status = (paddr == activity_status_byte_addr);
  assign hit_osc = (paddr == osc_select_byte_addr);
  assign mapped = hit_ctrl || hit_status || hit_osc;
  assign pready = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && hit_status));
  assign ctrl_write = wr && hit_ctrl && pstrb[0];
  assign wr_div = pwdata[divider_select_hi_pos:divider_select_lo_pos];

  // legal transitions: to 01 anytime, to 10/11 only from 01
  always_comb begin
    case (wr_div)
      2'b01: div_write_ok = 1'b1;
      2'b10, 2'b11: div_write_ok = (requested == div_full_speed);
      default: div_write_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // switchback sources
  // ---------------------------------------------------------------
  assign rx0_fall = rx0_prev && !serial0_rx_pin && serial0_rx_enable;
  assign rx1_fall = rx1_prev && !serial1_rx_pin && serial1_rx_enable;
  assign switchback_event = switchback_enable
    && (int_ack
    || rx0_fall || rx1_fall
    || serial0_tx_load || serial1_tx_load);

  always_ff @(posedge clk) begin
    if (rst) begin
      rx0_prev <= 1'b1;
      rx1_prev <= 1'b1;
    end else begin
      rx0_prev <= serial0_rx_pin;
      rx1_prev <= serial1_rx_pin;
    end
  end

  // ---------------------------------------------------------------
  // control register: requested divider and switchback enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      requested <= divider_select_reset;
    end else if (switchback_event) begin
      requested <= div_full_speed;
    end else if (ctrl_write && div_write_ok) begin
      requested <= divider_select_t'(wr_div);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      switchback_enable <= switchback_enable_reset;
    end else if (ctrl_write) begin
      switchback_enable <= pwdata[switchback_enable_pos];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ring_osc_run <= ring_run_reset;
    end else if (wr && hit_osc && pstrb[0]) begin
      ring_osc_run <= pwdata[ring_run_pos];
    end
  end

  // ---------------------------------------------------------------
  // applied divider, updated at machine-cycle boundary
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      divider_select <= divider_select_reset;
    end else if (cycle_end) begin
      // a move between the two reduced rates passes through full speed
      if (requested != divider_select && requested != div_full_speed
          && divider_select != div_full_speed) begin
        divider_select <= div_full_speed;
      end else begin
        divider_select <= requested;
      end
    end
  end

  machine_cycle_timer #(
    .width(phase_count_width)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .divider(divider_select),
    .cycle_end(cycle_end),
    .phase(phase)
  );

  assign machine_cycle_end = cycle_end;
  assign machine_phase = phase;

  // ---------------------------------------------------------------
  // activity status
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      activity_status <= activity_status_reset;
    end else begin
      activity_status[power_fail_in_progress_pos] <= power_fail_in_service;
      activity_status[high_prio_in_progress_pos] <= high_prio_in_progress;
      activity_status[low_prio_in_progress_pos] <= low_prio_in_progress;
      activity_status[4] <= 1'b0;
      activity_status[serial1_tx_active_pos] <= serial1_tx_busy;
      activity_status[serial1_rx_active_pos] <= serial1_rx_busy;
      activity_status[serial0_tx_active_pos] <= serial0_tx_busy;
      activity_status[serial0_rx_active_pos] <= serial0_rx_busy;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (paddr == power_mgmt_control_byte_addr) begin
        prdata[divider_select_hi_pos:divider_select_lo_pos] <= requested;
        prdata[switchback_enable_pos] <= switchback_enable;
      end else if (paddr == activity_status_byte_addr) begin
        prdata[7:0] <= activity_status;
      end else if (paddr == osc_select_byte_addr) begin
        prdata[ring_run_pos] <= ring_osc_run;
      end
    end
  end
endmodule

// ### tb/pm_clock_assertions.sv
// checker: port assertions for the power-management clock divider
`timescale 1ns/1ps
module pm_clock_checker
  import pm_clock_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire divider_select_t divider_select,
  input wire logic machine_cycle_end,
  input wire logic [1:0] machine_phase,
  input wire logic ring_osc_run
);
  logic [10:0] cnt;
  logic [10:0] pos;
  logic [10:0] exp_len;
  logic [1:0] exp_phase;
  logic mapped;

  // helper: clocks counted since the last machine-cycle end
  always_ff @(posedge clk) begin
    if (rst || machine_cycle_end) begin
      cnt <= 11'h001;
    end else begin
      cnt <= cnt + 11'h001;
    end
  end

  // expected cycle length and quarter-cycle phase per applied divider
  always_comb begin
    pos = cnt - 11'h001;
    case (divider_select)
      reduced_speed_div64: begin
        exp_len = 11'h040;
        exp_phase = pos[5:4];
      end
      reduced_speed_div1024: begin
        exp_len = 11'h400;
        exp_phase = pos[9:8];
      end
      default: begin
        exp_len = 11'h004;
        exp_phase = pos[1:0];
      end
    endcase
  end

  assign mapped = paddr inside {power_mgmt_control_byte_addr, activity_status_byte_addr,
    osc_select_byte_addr};

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence access_s;
    psel && penable;
  endsequence
  sequence rd_s(logic [11:0] a);
    access_s ##0 !pwrite && paddr == a;
  endsequence
  sequence wr_s(logic [11:0] a);
    access_s ##0 pwrite && paddr == a;
  endsequence
  sequence div_move_s;
    !$stable(divider_select);
  endsequence
  cycle_len_a: assert property (machine_cycle_end |-> cnt == exp_len)
    else $error("machine cycle length wrong");
  phase_walk_a: assert property (machine_phase == exp_phase)
    else $error("machine phase wrong");
  div_boundary_a: assert property (div_move_s |-> $past(machine_cycle_end))
    else $error("divider changed mid cycle");
  div_path_a: assert property (div_move_s |->
    divider_select == div_full_speed || $past(divider_select) == div_full_speed)
    else $error("illegal divider transition");
  status_wr_a: assert property (wr_s(activity_status_byte_addr) |-> pslverr)
    else $error("status write not refused");
  status_pad_a: assert property (rd_s(activity_status_byte_addr) |->
    prdata[31:8] == 24'h0 && !prdata[4])
    else $error("status unused bits set");
  ctrl_read_a: assert property (rd_s(power_mgmt_control_byte_addr) |->
    prdata[7:6] != 2'h0 && prdata[4:0] == 5'h00)
    else $error("control read bad");
  unmapped_a: assert property (access_s ##0 !mapped |-> pslverr)
    else $error("unmapped access not refused");
  ring_sel_a: assert property (wr_s(osc_select_byte_addr) ##0 pstrb[0] |->
    ##1 ring_osc_run == $past(pwdata[0]))
    else $error("ring select not written");
  ring_hold_a: assert property (wr_s(osc_select_byte_addr) ##0 !pstrb[0] |->
    ##1 $stable(ring_osc_run))
    else $error("ring select written without strobe");
endmodule
bind power_mgmt_clock_divider pm_clock_checker chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr), .divider_select(divider_select),
  .machine_cycle_end(machine_cycle_end), .machine_phase(machine_phase),
  .ring_osc_run(ring_osc_run));

// ### tb/tb.sv
// testbench: power-management clock divider against a bench model
`timescale 1ns/1ps
module tb;
  import pm_clock_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, ring;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] ev = 3'h0;
  logic [1:0] rxp = 2'h3, rx_en = 2'h3;
  logic [6:0] st = 7'h00;
  divider_select_t divider_select;
  logic [7:0] walk [8] = '{8'h80, 8'hC0, 8'h40, 8'hC0, 8'h80, 8'h00, 8'h40, 8'h80};
  int mismatches = 0, cmp_count = 0, cycles = 0, req = 1, swb = 0;
  power_mgmt_clock_divider dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .int_ack(ev[0]), .power_fail_in_service(st[6]),
    .high_prio_in_progress(st[5]), .low_prio_in_progress(st[4]),
    .serial0_rx_enable(rx_en[0]), .serial1_rx_enable(rx_en[1]), .serial0_rx_pin(rxp[0]),
    .serial1_rx_pin(rxp[1]), .serial0_tx_load(ev[1]), .serial1_tx_load(ev[2]),
    .serial0_tx_busy(st[1]), .serial1_tx_busy(st[3]), .serial0_rx_busy(st[0]),
    .serial1_rx_busy(st[2]), .divider_select(divider_select), .machine_phase(),
    .machine_cycle_end(), .ring_osc_run(ring));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr_ctl(input logic [7:0] d);
    apb(power_mgmt_control_byte_addr, 1'b1, {24'h0, d});
    if (d[7:6] == 2'h1 || (d[7:6] != 2'h0 && req == 1)) req = d[7:6];
    swb = d[5];
  endtask
  task automatic settle();
    int n;
    n = 0;
    @(negedge clk);
    while (divider_select !== req[1:0] && n < 1100) begin
      @(negedge clk);
      n++;
    end
    check("divider", req, divider_select);
    @(posedge clk);
    apb(power_mgmt_control_byte_addr, 1'b0, 32'h0);
    check("control", {req[1:0], swb[0], 5'h00}, rd);
  endtask
  task automatic events(input logic [4:0] e);
    ev <= e[2:0];
    rxp <= ~e[4:3];
    @(posedge clk);
    ev <= 3'h0;
    @(posedge clk);
    rxp <= 2'h3;
    @(posedge clk);
  endtask
  initial begin
    void'($urandom(63346));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("divider", 32'h1, divider_select);
    @(posedge clk);
    apb(activity_status_byte_addr, 1'b0, 32'h0);
    check("status", 32'h0, rd);
    settle();
    foreach (walk[i]) begin
      wr_ctl(walk[i]);
      settle();
      events(5'h1F);
      settle();
    end
    for (int s = 0; s < 5; s++) begin
      wr_ctl(8'h60);
      apb(activity_status_byte_addr, 1'b0, 32'h0);
      check("status", 32'h0, rd);
      wr_ctl(s[0] ? 8'hA0 : 8'hE0);
      settle();
      events(5'h01 << s);
      req = 1;
      settle();
    end
    rx_en <= 2'h0;
    wr_ctl(8'h60);
    wr_ctl(8'hA0);
    settle();
    events(5'h18);
    settle();
    rx_en <= 2'h3;
    repeat (12) begin
      st <= 7'($urandom);
      repeat (3) @(posedge clk);
      apb(activity_status_byte_addr, 1'b0, 32'h0);
      check("status", {st[6:4], 1'b0, st[3:0]}, rd);
    end
    apb(osc_select_byte_addr, 1'b1, 32'h1);
    check("ring", 32'h1, ring);
    pstrb <= 4'hE;
    apb(osc_select_byte_addr, 1'b1, 32'h0);
    pstrb <= 4'hF;
    apb(osc_select_byte_addr, 1'b0, 32'h0);
    check("ring_rd", 32'h1, rd);
    check("ring_hold", 32'h1, ring);
    apb(activity_status_byte_addr, 1'b1, 32'hFF);
    check("status_err", 32'h1, err);
    apb(12'h200, 1'b0, 32'h0);
    check("unmapped_err", 32'h1, err);
    check("unmapped_rd", 32'h0, rd);
    print_verdict();
  end
endmodule
